//--- verilog/ffrh_codec.sv
// repair header parser and single-loss recovery engine with wishbone registers
// How it works
// [R01] R=0,F=0: mask layout.
// [R02] R=0,F=1: L and D layout.
// [R03] R=1,F=0: one packet retransmitted.
// [R04] R=1,F=1 dropped silently.
// [R05] sender: R set only for retransmission.
// [R06] sender: F clear when R set.
// [R07] recovered P X CC M PT from recovery fields.
// [R08] length counts octets past fixed header.
// [R09] recovered timestamp from recovery field.
// [R10] one base block per source id, in order.
// [R11] base is lowest number, modulo 2^16.
// [R12] mask bit j, msb first, covers base+j.
// [R13] k bit: mask of 15, 46 or 110.
// [R14] payload covers all past fixed header; the code buffers only the first BUF_DEPTH words of it.
// [R15] L/D layout: base, L, D per stream.
// [R16] L=0,D=0: session counts.
// [R17] L>0,D=0: row from base.
// [R18] sender: rows before columns.
// [R19] L>0,D>1: column, spacing L, D rows.
// [R20] retransmission: sequence in length slot.
// [R21] retransmission: source id in header.
// [R22] sender: original behind new RTP header.
// [R23] RTP version 2 only.
// [R24] repair sequence rises by one.
// [R25] recovery by exclusive-or.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "ffrh_map.svh"
module ffrh_codec #(
    parameter int BUF_DEPTH = 64,
    parameter int MAX_D = 255,
    parameter int AW = $clog2(BUF_DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rp_valid_i,
    input wire logic [31:0] rp_data_i,
    input wire logic rp_last_i,
    output logic rp_ready_o,
    input wire logic sp_valid_i,
    input wire logic [31:0] sp_data_i,
    input wire logic sp_last_i,
    input wire logic [15:0] sp_len_i,
    output logic sp_ready_o,
    output logic pd_valid_o,
    output ffrh_pkg::ffrh_desc_s pd_o,
    output logic rc_valid_o,
    output logic [31:0] rc_data_o,
    output logic rc_last_o,
    input wire logic rc_ready_i
);
    typedef struct packed {
        ffrh_pkg::ffrh_pst_e st;
        logic [3:0] cc;
        logic [3:0] sidx;
        logic [14:0][31:0] csrc;
        ffrh_pkg::ffrh_desc_s desc;
        ffrh_pkg::ffrh_desc_s dsc0;
        logic pdv;
        ffrh_pkg::ffrh_desc_s pdo;
        logic [15:0] pcnt;
        logic [7:0] drops;
        ffrh_pkg::ffrh_var_e kind;
        ffrh_pkg::ffrh_acc_s acc;
        logic [15:0] scnt;
        logic en;
        ffrh_pkg::ffrh_cfg_s cfg;
        logic [15:0] rseq;
        logic busy;
        logic [15:0] ocnt;
        logic rcv;
        logic rcl;
        logic [31:0] rcd;
        logic ack;
        logic [31:0] dat;
    } ffrh_cd_st_s;

    ffrh_cd_st_s q;
    ffrh_cd_st_s next_q;

    ffrh_pkg::ffrh_rtp0_s w_rtp;
    ffrh_pkg::ffrh_fec0_s w_fec;
    ffrh_pkg::ffrh_mseg0_s w_ms0;
    ffrh_pkg::ffrh_mseg1_s w_ms1;
    ffrh_pkg::ffrh_ld_s w_ld;
    ffrh_pkg::ffrh_rtp0_s s_rtp;
    ffrh_pkg::ffrh_stat_s stat;
    logic rp_go;
    logic sp_go;
    logic rp_pay;
    logic sp_pay;
    logic [15:0] sp_off;
    logic buf_wr;
    logic [AW-1:0] buf_wa;
    logic [31:0] buf_wd;
    logic [AW-1:0] buf_ra;
    logic [31:0] buf_rd;
    logic wr_hit;
    logic [7:0] adr;
    logic clr;
    logic emit;
    logic dsc_done;
    logic hit;
    logic [15:0] nwords;
    logic [15:0] last_idx;
    logic [15:0] nidx;
    logic [31:0] nword;
    logic [31:0] rd_val;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] val,
        input logic [3:0] sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (val & m);
    endfunction : merge

    assign w_rtp = rp_data_i;
    assign w_fec = rp_data_i;
    assign w_ms0 = rp_data_i;
    assign w_ms1 = rp_data_i;
    assign w_ld = rp_data_i;
    assign s_rtp = sp_data_i;

    // output reads the buffer, so inputs wait
    assign rp_ready_o = q.en && !q.busy;
    assign sp_ready_o = q.en && !q.busy && !(rp_valid_i && q.st == ffrh_pkg::FFRH_PS_PAY);
    assign rp_go = rp_valid_i && rp_ready_o;
    assign sp_go = sp_valid_i && sp_ready_o;

    assign rp_pay = rp_go && q.st == ffrh_pkg::FFRH_PS_PAY && q.pcnt < 16'(BUF_DEPTH); // R14
    assign sp_off = q.scnt - `FFRH_FIXED_WORDS;
    assign sp_pay = sp_go && q.scnt >= `FFRH_FIXED_WORDS && sp_off < 16'(BUF_DEPTH); // R14
    assign buf_wr = rp_pay || sp_pay;
    assign buf_wa = rp_pay ? AW'(q.pcnt) : AW'(sp_off);
    assign buf_wd = rp_pay ? rp_data_i : sp_data_i;

    assign adr = {wb_adr_i[7:2], 2'h0};
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
    assign clr = wr_hit && adr == `FFRH_ADR_CTRL && wb_sel_i[0] && wb_dat_i[`FFRH_CTRL_CLR];
    assign emit = wr_hit && adr == `FFRH_ADR_CTRL && wb_sel_i[0] && wb_dat_i[`FFRH_CTRL_EMIT];

    // payload octets round up to whole words
    assign nwords = 16'((17'(q.acc.len) + `FFRH_WORD_RND) >> `FFRH_WORD_SHIFT); // R08
    assign last_idx = nwords + `FFRH_FIXED_WORDS - 16'h0001;
    assign nidx = q.busy ? q.ocnt + 16'h0001 : 16'h0000;
    assign buf_ra = AW'(nidx - `FFRH_FIXED_WORDS);

    always_comb
    begin
        case (nidx)
            16'h0000: nword = {`FFRH_RTP_VER, q.acc.rf, q.rseq}; // R07
            16'h0001: nword = q.acc.ts; // R09
            16'h0002: nword = q.dsc0.ssrc;
            default: nword = buf_rd; // R25
        endcase
    end

    ffrh_xor_buf #(
        .W(32),
        .DEPTH(BUF_DEPTH),
        .AW(AW)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clr_i(clr),
        .wr_i(buf_wr),
        .wr_addr_i(buf_wa),
        .wr_data_i(buf_wd),
        .rd_addr_i(buf_ra),
        .rd_data_o(buf_rd)
    );

    ffrh_prot_chk #(
        .MAX_D(MAX_D)
    ) u_chk (
        .desc_i(q.dsc0),
        .cfg_l_i(q.cfg.l),
        .cfg_d_i(q.cfg.d),
        .seq_i(q.rseq),
        .hit_o(hit)
    );

    assign stat = {8'h00, q.drops, 13'h0000, q.busy, q.kind};

    always_comb
    begin
        case (adr)
            `FFRH_ADR_CTRL: rd_val = {31'h0000_0000, q.en};
            `FFRH_ADR_CFG: rd_val = q.cfg;
            `FFRH_ADR_STAT: rd_val = stat;
            `FFRH_ADR_RSEQ: rd_val = {15'h0000, hit, q.rseq};
            `FFRH_ADR_RHDR: rd_val = {`FFRH_RTP_VER, q.acc.rf, q.rseq};
            `FFRH_ADR_RTS: rd_val = q.acc.ts;
            `FFRH_ADR_RLEN: rd_val = {16'h0000, q.acc.len};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_q = q;
        next_q.pdv = 1'b0;
        dsc_done = 1'b0;

        // ack one cycle after the request
        next_q.ack = wb_cyc_i && wb_stb_i && !q.ack;
        if (wb_cyc_i && wb_stb_i && !q.ack)
        begin
            next_q.dat = rd_val;
        end
        if (wr_hit && adr == `FFRH_ADR_CTRL && wb_sel_i[0])
        begin
            next_q.en = wb_dat_i[`FFRH_CTRL_EN];
        end
        if (wr_hit && adr == `FFRH_ADR_CFG)
        begin
            next_q.cfg = merge(32'(q.cfg), wb_dat_i, wb_sel_i);
            next_q.cfg.rsv = '0;
        end
        if (wr_hit && adr == `FFRH_ADR_RSEQ)
        begin
            next_q.rseq = 16'(merge({16'h0000, q.rseq}, wb_dat_i, wb_sel_i));
        end
        // clear first: same-cycle input survives
        if (clr)
        begin
            next_q.acc = '0;
        end

        if (rp_go)
        begin
            case (q.st)
                ffrh_pkg::FFRH_PS_RTP0:
                begin
                    next_q.pcnt = 16'h0000;
                    if (w_rtp.ver != `FFRH_RTP_VER) // R23
                    begin
                        next_q.st = ffrh_pkg::FFRH_PS_DROP;
                    end
                    else
                    begin
                        next_q.cc = w_rtp.rf.cc;
                        next_q.st = ffrh_pkg::FFRH_PS_RTP1;
                    end
                end
                ffrh_pkg::FFRH_PS_RTP1: next_q.st = ffrh_pkg::FFRH_PS_RTP2;
                ffrh_pkg::FFRH_PS_RTP2:
                begin
                    next_q.sidx = 4'h0;
                    next_q.st = (q.cc != 4'h0) ? ffrh_pkg::FFRH_PS_CSRC : ffrh_pkg::FFRH_PS_FEC0;
                end
                ffrh_pkg::FFRH_PS_CSRC:
                begin
                    next_q.csrc[q.sidx] = rp_data_i; // R10
                    next_q.sidx = q.sidx + 4'h1;
                    if (q.sidx == q.cc - 4'h1)
                    begin
                        next_q.st = ffrh_pkg::FFRH_PS_FEC0;
                    end
                end
                ffrh_pkg::FFRH_PS_FEC0:
                begin
                    next_q.kind = ffrh_pkg::ffrh_var_e'({w_fec.r, w_fec.f});
                    next_q.desc = '0;
                    next_q.desc.kind = next_q.kind;
                    if (next_q.kind == ffrh_pkg::FFRH_VAR_BAD) // R04
                    begin
                        next_q.drops = q.drops + 8'h01;
                        next_q.st = ffrh_pkg::FFRH_PS_DROP;
                    end
                    else
                    begin
                        next_q.acc.rf = next_q.acc.rf ^ w_fec.rf; // R07
                        if (next_q.kind == ffrh_pkg::FFRH_VAR_RTX)
                        begin
                            next_q.desc.base = w_fec.len; // R20
                        end
                        else
                        begin
                            next_q.acc.len = next_q.acc.len ^ w_fec.len; // R08
                        end
                        next_q.st = ffrh_pkg::FFRH_PS_FEC1;
                    end
                end
                ffrh_pkg::FFRH_PS_FEC1:
                begin
                    next_q.acc.ts = next_q.acc.ts ^ rp_data_i; // R09
                    next_q.sidx = 4'h0;
                    if (q.kind == ffrh_pkg::FFRH_VAR_RTX) // R03
                    begin
                        next_q.st = ffrh_pkg::FFRH_PS_RSSRC;
                    end
                    else
                    begin
                        next_q.st = (q.cc != 4'h0) ? ffrh_pkg::FFRH_PS_BASE : ffrh_pkg::FFRH_PS_PAY;
                    end
                end
                ffrh_pkg::FFRH_PS_RSSRC:
                begin
                    next_q.desc.ssrc = rp_data_i; // R21
                    dsc_done = 1'b1;
                end
                ffrh_pkg::FFRH_PS_BASE:
                begin
                    next_q.desc.idx = q.sidx;
                    next_q.desc.ssrc = q.csrc[q.sidx]; // R10
                    next_q.desc.mask = '0;
                    if (q.kind == ffrh_pkg::FFRH_VAR_LD) // R02
                    begin
                        next_q.desc.base = w_ld.base; // R15
                        next_q.desc.l = w_ld.l;
                        next_q.desc.d = w_ld.d;
                        dsc_done = 1'b1;
                    end
                    else // R01
                    begin
                        next_q.desc.base = w_ms0.base; // R11
                        next_q.desc.mask.m15 = w_ms0.m; // R12
                        next_q.st = w_ms0.k ? ffrh_pkg::FFRH_PS_MSK1 : q.st; // R13
                        dsc_done = !w_ms0.k;
                    end
                end
                ffrh_pkg::FFRH_PS_MSK1:
                begin
                    next_q.desc.mask.m31 = w_ms1.m;
                    next_q.st = w_ms1.k ? ffrh_pkg::FFRH_PS_MSK2 : q.st; // R13
                    dsc_done = !w_ms1.k;
                end
                ffrh_pkg::FFRH_PS_MSK2:
                begin
                    next_q.desc.mask.m64h = rp_data_i;
                    next_q.st = ffrh_pkg::FFRH_PS_MSK3;
                end
                ffrh_pkg::FFRH_PS_MSK3:
                begin
                    next_q.desc.mask.m64l = rp_data_i;
                    dsc_done = 1'b1;
                end
                ffrh_pkg::FFRH_PS_PAY: next_q.pcnt = q.pcnt + 16'h0001; // R14
                ffrh_pkg::FFRH_PS_DROP: next_q.st = ffrh_pkg::FFRH_PS_DROP;
                default: next_q.st = ffrh_pkg::FFRH_PS_RTP0;
            endcase
            if (dsc_done)
            begin
                next_q.pdv = 1'b1;
                next_q.pdo = next_q.desc;
                next_q.sidx = q.sidx + 4'h1;
                if (q.sidx == 4'h0)
                begin
                    next_q.dsc0 = next_q.desc;
                end
                next_q.st = (q.kind == ffrh_pkg::FFRH_VAR_RTX || q.sidx + 4'h1 >= q.cc) ? // R10
                    ffrh_pkg::FFRH_PS_PAY : ffrh_pkg::FFRH_PS_BASE;
            end
            // a truncated packet still ends at its last word
            if (rp_last_i)
            begin
                next_q.st = ffrh_pkg::FFRH_PS_RTP0;
            end
        end

        if (sp_go)
        begin
            if (q.scnt == 16'h0000)
            begin
                next_q.acc.rf = next_q.acc.rf ^ s_rtp.rf; // R25
                next_q.acc.len = next_q.acc.len ^ sp_len_i; // R25
            end
            else if (q.scnt == 16'h0001)
            begin
                next_q.acc.ts = next_q.acc.ts ^ sp_data_i; // R25
            end
            next_q.scnt = sp_last_i ? 16'h0000 : q.scnt + 16'h0001;
        end

        if (q.busy)
        begin
            if (rc_ready_i && q.rcv)
            begin
                if (q.rcl)
                begin
                    next_q.busy = 1'b0;
                    next_q.rcv = 1'b0;
                    next_q.rcl = 1'b0;
                end
                else
                begin
                    next_q.ocnt = nidx;
                    next_q.rcd = nword;
                    next_q.rcl = nidx == last_idx;
                end
            end
        end
        else if (emit)
        begin
            next_q.busy = 1'b1;
            next_q.ocnt = 16'h0000;
            next_q.rcv = 1'b1;
            next_q.rcd = nword;
            next_q.rcl = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.en <= `FFRH_RST_EN;
            q.cfg <= `FFRH_RST_CFG;
            q.st <= ffrh_pkg::FFRH_PS_RTP0;
        end
        else if (ce_i)
        begin
            q <= next_q;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign pd_valid_o = q.pdv;
    assign pd_o = q.pdo;
    assign rc_valid_o = q.rcv;
    assign rc_data_o = q.rcd;
    assign rc_last_o = q.rcl;
endmodule : ffrh_codec

//--- shared/ffrh_map.svh
// register map, field values and fixed counts of the repair header codec
`ifndef FFRH_MAP_SVH
`define FFRH_MAP_SVH
`define FFRH_ADR_CTRL 8'h00
`define FFRH_ADR_CFG 8'h04
`define FFRH_ADR_STAT 8'h08
`define FFRH_ADR_RSEQ 8'h0c
`define FFRH_ADR_RHDR 8'h10
`define FFRH_ADR_RTS 8'h14
`define FFRH_ADR_RLEN 8'h18
`define FFRH_CTRL_EN 0
`define FFRH_CTRL_CLR 1
`define FFRH_CTRL_EMIT 2
`define FFRH_RST_EN 1'h0
`define FFRH_RST_CFG 32'h0000_0000
`define FFRH_RTP_VER 2'h2
`define FFRH_FIXED_WORDS 16'h0003
`define FFRH_WORD_RND 17'h0_0003
`define FFRH_WORD_SHIFT 2
`define FFRH_MASK_W 16'h006e
`endif

//--- shared/ffrh_pkg.sv
// types shared by the repair header codec
package ffrh_pkg;
    typedef enum logic [1:0] {
        FFRH_VAR_MASK = 2'h0,
        FFRH_VAR_LD = 2'h1,
        FFRH_VAR_RTX = 2'h2,
        FFRH_VAR_BAD = 2'h3
    } ffrh_var_e;
    typedef enum logic [3:0] {
        FFRH_PS_RTP0 = 4'h0,
        FFRH_PS_RTP1 = 4'h1,
        FFRH_PS_RTP2 = 4'h2,
        FFRH_PS_CSRC = 4'h3,
        FFRH_PS_FEC0 = 4'h4,
        FFRH_PS_FEC1 = 4'h5,
        FFRH_PS_RSSRC = 4'h6,
        FFRH_PS_BASE = 4'h7,
        FFRH_PS_MSK1 = 4'h8,
        FFRH_PS_MSK2 = 4'h9,
        FFRH_PS_MSK3 = 4'ha,
        FFRH_PS_PAY = 4'hb,
        FFRH_PS_DROP = 4'hc
    } ffrh_pst_e;
    typedef struct packed {
        logic p;
        logic x;
        logic [3:0] cc;
        logic m;
        logic [6:0] pt;
    } ffrh_rf_s;
    typedef struct packed {
        logic [1:0] ver;
        ffrh_rf_s rf;
        logic [15:0] sn;
    } ffrh_rtp0_s;
    typedef struct packed {
        logic r;
        logic f;
        ffrh_rf_s rf;
        logic [15:0] len;
    } ffrh_fec0_s;
    typedef struct packed {
        logic [15:0] base;
        logic k;
        logic [14:0] m;
    } ffrh_mseg0_s;
    typedef struct packed {
        logic k;
        logic [30:0] m;
    } ffrh_mseg1_s;
    typedef struct packed {
        logic [15:0] base;
        logic [7:0] l;
        logic [7:0] d;
    } ffrh_ld_s;
    typedef struct packed {
        logic [14:0] m15;
        logic [30:0] m31;
        logic [31:0] m64h;
        logic [31:0] m64l;
    } ffrh_mask_s;
    typedef struct packed {
        logic [3:0] idx;
        ffrh_var_e kind;
        logic [31:0] ssrc;
        logic [15:0] base;
        ffrh_mask_s mask;
        logic [7:0] l;
        logic [7:0] d;
    } ffrh_desc_s;
    typedef struct packed {
        ffrh_rf_s rf;
        logic [15:0] len;
        logic [31:0] ts;
    } ffrh_acc_s;
    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] d;
        logic [7:0] l;
    } ffrh_cfg_s;
    typedef struct packed {
        logic [7:0] rsv;
        logic [7:0] drops;
        logic [12:0] rsv2;
        logic busy;
        ffrh_var_e kind;
    } ffrh_stat_s;
endpackage : ffrh_pkg

//--- verilog/ffrh_xor_buf.sv
// word buffer that folds every write into its entry by exclusive-or
module ffrh_xor_buf #(
    parameter int W = 32,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);
    typedef struct packed {
        logic [DEPTH-1:0] vld;
        logic [DEPTH-1:0][W-1:0] mem;
    } ffrh_xb_st_s;
    ffrh_xb_st_s q;
    ffrh_xb_st_s next_q;
    logic [W-1:0] old;

    // a clear and a write in one cycle keep the write
    always_comb
    begin
        next_q = q;
        if (clr_i)
        begin
            next_q.vld = '0;
        end
        old = next_q.vld[wr_addr_i] ? q.mem[wr_addr_i] : '0;
        if (wr_i)
        begin
            next_q.mem[wr_addr_i] = old ^ wr_data_i; // R25
            next_q.vld[wr_addr_i] = 1'b1;
        end
    end

    assign rd_data_o = q.vld[rd_addr_i] ? q.mem[rd_addr_i] : '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else if (ce_i)
        begin
            q <= next_q;
        end
    end
endmodule : ffrh_xor_buf

//--- verilog/ffrh_prot_chk.sv
// decides whether a sequence number is covered by a repair descriptor
`include "ffrh_map.svh"
module ffrh_prot_chk #(
    parameter int MAX_D = 255
) (
    input ffrh_pkg::ffrh_desc_s desc_i,
    input wire logic [7:0] cfg_l_i,
    input wire logic [7:0] cfg_d_i,
    input wire logic [15:0] seq_i,
    output logic hit_o
);
    logic [15:0] off;
    logic [7:0] eff_l;
    logic [7:0] eff_d;
    logic [109:0] sh;
    logic [MAX_D-1:0] col;
    logic use_cfg;

    assign off = seq_i - desc_i.base; // R11
    assign use_cfg = (desc_i.l == 8'h00) && (desc_i.d == 8'h00);
    assign eff_l = use_cfg ? cfg_l_i : desc_i.l; // R16
    assign eff_d = use_cfg ? cfg_d_i : desc_i.d; // R16
    assign sh = desc_i.mask << off;

    // one comparator per row keeps the column test free of a divider
    for (genvar gi = 0; gi < MAX_D; gi++)
    begin : g_col
        assign col[gi] = (8'(gi) < eff_d) && (off == 16'(16'(gi) * {8'h00, eff_l})); // R19
    end

    always_comb
    begin
        case (desc_i.kind)
            ffrh_pkg::FFRH_VAR_MASK: hit_o = (off < `FFRH_MASK_W) && sh[$bits(sh)-1]; // R12
            ffrh_pkg::FFRH_VAR_LD:
            begin
                if (eff_d <= 8'h01)
                begin
                    hit_o = off < {8'h00, eff_l}; // R17
                end
                else
                begin
                    hit_o = |col; // R19
                end
            end
            ffrh_pkg::FFRH_VAR_RTX: hit_o = off == 16'h0000; // R03
            default: hit_o = 1'b0;
        endcase
    end
endmodule : ffrh_prot_chk

//--- tb/ffrh_codec_sva.sv
// port-level checks of the repair header codec
module ffrh_codec_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pd_valid_o,
    input ffrh_pkg::ffrh_desc_s pd_o,
    input wire logic rc_valid_o,
    input wire logic [31:0] rc_data_o,
    input wire logic rc_ready_i
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_due: assert property (s_req |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i)) else $error("stray ack");
    a_pd_legal: assert property (pd_valid_o |-> pd_o.kind != ffrh_pkg::FFRH_VAR_BAD)
        else $error("bad kind");
    a_pd_hold: assert property (!pd_valid_o |-> $stable(pd_o)) else $error("pd moved");
    a_rc_stay: assert property (rc_valid_o && !rc_ready_i |=> rc_valid_o) else $error("rc dropped");
    a_rc_hold: assert property (rc_valid_o && !rc_ready_i |=> $stable(rc_data_o)) else $error("rc moved");
    a_rc_ver: assert property ($rose(rc_valid_o) |-> rc_data_o[31:30] == 2'h2) else $error("rc ver");
endmodule : ffrh_codec_sva
bind ffrh_codec ffrh_codec_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pd_valid_o(pd_valid_o), .pd_o(pd_o), .rc_valid_o(rc_valid_o),
    .rc_data_o(rc_data_o), .rc_ready_i(rc_ready_i));

//--- tb/ffrh_peer.sv
// far-end sender model for the repair and source streams
module ffrh_peer (
    input wire logic clk_i,
    input wire logic rp_ready_i,
    input wire logic sp_ready_i,
    output logic rp_valid_o = 1'h0,
    output logic sp_valid_o = 1'h0,
    output logic [31:0] dat_o = 32'h0,
    output logic last_o = 1'h0,
    output logic [15:0] len_o = 16'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CSRC = 32'h5eed_0001;
    logic [15:0] seq = 16'h0100;
    task automatic send(input logic s, input logic [15:0] ln, input logic [31:0] q[$]);
        foreach (q[i])
        begin
            {sp_valid_o, rp_valid_o, dat_o, len_o} <= {s, !s, q[i], ln};
            last_o <= i == q.size() - 1;
            @(posedge clk_i);
            while (!(s ? sp_ready_i : rp_ready_i))
                @(posedge clk_i);
        end
        {sp_valid_o, rp_valid_o} <= 2'h0;
        dat_o <= ~dat_o; // released data must not look valid
    endtask : send
    task automatic rep(input logic r, input logic f, input logic [15:0] ln, input logic [31:0] q[$]);
        logic [31:0] h[$];
        h = '{{2'h2, 14'(!r) << 8, seq}, 32'h0, 32'h7e57_0000};
        if (!r)
            h.push_back(CSRC);
        h.push_back({r, f && !r, 14'h1234, ln});
        seq++;
        send(1'h0, 16'h0, {h, q});
    endtask : rep
endmodule : ffrh_peer

//--- tb/tb.sv
// self-checking bench for the repair header codec
`include "ffrh_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc = 1'h0;
    logic we = 1'h0;
    logic rc_rdy = 1'h0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic rp_v, sp_v, lst, ack, pd_v, rp_r, sp_r, rc_v, rc_l;
    logic [31:0] dat, rd, rdat, rc_d;
    logic [15:0] len;
    ffrh_pkg::ffrh_desc_s pd;
    logic [31:0] rcq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int n_pd = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        rc_rdy <= ~rc_rdy;
        n_pd <= n_pd + int'(pd_v === 1'h1);
        if (rc_v && rc_rdy)
            rcq.push_back(rc_l ? ~rc_d : rc_d);
    end
    ffrh_codec #(.MAX_D(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rp_valid_i(rp_v), .rp_data_i(dat), .rp_last_i(lst), .rp_ready_o(rp_r), .sp_valid_i(sp_v),
        .sp_data_i(dat), .sp_last_i(lst), .sp_len_i(len), .sp_ready_o(sp_r), .pd_valid_o(pd_v),
        .pd_o(pd), .rc_valid_o(rc_v), .rc_data_o(rc_d), .rc_last_o(rc_l), .rc_ready_i(rc_rdy));
    ffrh_peer u_peer (.clk_i(clk_i), .rp_ready_i(rp_r), .sp_ready_i(sp_r), .rp_valid_o(rp_v),
        .sp_valid_o(sp_v), .dat_o(dat), .last_o(lst), .len_o(len));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        {cyc, we, adr, sel, wdat} <= {1'h1, w, a, s, d};
        @(posedge clk_i);
        while (ack !== 1'h1)
            @(posedge clk_i);
        rd = rdat;
        cyc <= 1'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 4'hf, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic t_reg;
        rdc(`FFRH_ADR_CFG, `FFRH_RST_CFG);
        wb(1'h1, `FFRH_ADR_CFG, 4'hf, 32'hffff_0503);
        wb(1'h1, `FFRH_ADR_CFG, 4'h1, 32'h2);
        rdc(`FFRH_ADR_CFG, 32'h502);
        rdc(8'h1c, 32'h0);
        $display("done registers");
    endtask : t_reg
    task automatic t_rec;
        int n0;
        n0 = n_pd;
        wb(1'h1, `FFRH_ADR_CTRL, 4'hf, 32'h3);
        wb(1'h1, `FFRH_ADR_RSEQ, 4'hf, 32'h10);
        u_peer.rep(1'h0, 1'h0, 16'h8, '{32'h1111_2222, 32'h0010_4000, 32'haaaa_0000, 32'h5555});
        chk(32'(n_pd - n0), 32'h1);
        chk({pd.kind, pd.base, pd.mask.m15}, {ffrh_pkg::FFRH_VAR_MASK, 16'h10, 15'h4000});
        rdc(`FFRH_ADR_RSEQ, 32'h1_0010);
        u_peer.send(1'h1, 16'hc, '{32'h8040_0123, 32'h0f0f_0f0f, 32'h0, 32'h1234_5678});
        wb(1'h1, `FFRH_ADR_CTRL, 4'hf, 32'h5);
        while (rcq.size() < 4)
            @(posedge clk_i);
        chk(rcq[0], 32'h9274_0010);
        chk(rcq[1], 32'h1e1e_2d2d);
        chk(rcq[2], u_peer.CSRC);
        chk(rcq[3], ~32'hb89e_5678);
        $display("done recovery");
    endtask : t_rec
    task automatic t_ld;
        logic [63:0] c[4] = '{64'hfffe_0400_0001_0001, 64'hfffe_0401_0002_0000,
            64'h0100_0000_0108_0001, 64'h0100_0203_0106_0000};
        foreach (c[i])
        begin
            u_peer.rep(1'h0, 1'h1, 16'h4, '{32'h0, c[i][63:32], 32'h0});
            chk({pd.kind, pd.l, pd.d}, {ffrh_pkg::FFRH_VAR_LD, c[i][47:32]});
            wb(1'h1, `FFRH_ADR_RSEQ, 4'hf, {16'h0, c[i][31:16]});
            rdc(`FFRH_ADR_RSEQ, {15'h0, c[i][0], c[i][31:16]});
        end
        $display("done columns and rows");
    endtask : t_ld
    task automatic t_rtx;
        u_peer.rep(1'h1, 1'h1, 16'h42, '{32'h0, 32'h7777_0001, 32'hcafe_0000});
        chk({pd.kind, pd.ssrc, pd.base}, {ffrh_pkg::FFRH_VAR_RTX, 32'h7777_0001, 16'h42});
        rdc(`FFRH_ADR_STAT, 32'h2);
        $display("done retransmission");
    endtask : t_rtx
    task automatic t_bad;
        int n0;
        n0 = n_pd;
        u_peer.send(1'h0, 16'h0, '{32'h8000_0000, 32'h0, 32'h0, 32'hc000_0000, 32'h0, 32'h1});
        chk(32'(n_pd - n0), 32'h0);
        wb(1'h0, `FFRH_ADR_STAT, 4'hf, 32'h0);
        chk(rd[23:16], 32'h1);
        $display("done invalid header");
    endtask : t_bad
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reg();
        t_rec();
        t_ld();
        t_rtx();
        t_bad();
        wrap_up();
    end
    // tests need under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule : tb
